// file: core/swc_pkg.sv
// swc_pkg: constants and types for the switch command register block
// assumes a 16-bit register port with one-cycle read latency
package swc_pkg;
    localparam logic [15:0] SWC_CMD_OFFSET = 16'h0000;
    localparam int SWC_VER_MSB = 15;
    localparam int SWC_VER_LSB = 8;
    localparam int SWC_TEST_BIT = 7;
    localparam int SWC_CMD_MSB = 2;
    localparam int SWC_CMD_LSB = 0;
    localparam logic [2:0] SWC_CMD_STOP = 3'h0;
    localparam logic [2:0] SWC_CMD_ENABLE = 3'h7;
    localparam logic [2:0] SWC_CMD_RESET = 3'h0;
    localparam logic SWC_TEST_RESET = 1'b0;
    // version value is arbitrary: major 1, revision 0
    localparam logic [7:0] SWC_VERSION = 8'h10;
    localparam logic [15:0] SWC_RD_ZERO = 16'h0000;

    // register bus request
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } swc_req_t;

    // engine states
    typedef enum logic [2:0] {
        SWC_ST_IDLE = 3'b001,
        SWC_ST_RUN = 3'b010,
        SWC_ST_DRAIN = 3'b100
    } swc_state_t;
endpackage

// file: core/swc_sync_reg.sv
// swc_sync_reg: reset-to-constant storage register for command fields
// assumes a single clock and asynchronous active-low reset
`timescale 1ns/1ps
module swc_sync_reg import swc_pkg::*; #(
    parameter int W = 4,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // load on write strobe
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= RST;
        end else if (load) begin
            q <= d;
        end
    end
endmodule // swc_sync_reg

// file: core/swc_cmd_reg.sv
// swc_cmd_reg: command and version register, engine run control
// assumes the engine pulses cell_done at the end of each cell it handles
// assumes cell_active stays high while a cell is in flight
// assumes one-cycle strobes, never a write and a read together
// assumes read data are taken in the cycle after the read strobe
// Operation
// (R01) reserved bits are ignored on write and read back as zero.
// (R02) bits 15:8 read a fixed version, major nibble high, revision low.
// (R03) writes to the version field have no effect on it.
// (R04) test mode bit 7 resets to zero, is read/write, software keeps it zero.
// (R05) command field bits 2:0 resets to 000, 000 stops and 111 enables.
// (R06) software enables only after busy is clear and all setup is done.
// (R07) a stop waits until the cell in progress is finished.
// (R08) software restarts only after confirming busy is clear.
// (R09) software sets the secondary config register before the first command.
// (R10) command codes other than 000 and 111 leave the engine state unchanged.
`timescale 1ns/1ps
module swc_cmd_reg import swc_pkg::*; (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic cell_active,
    input wire logic cell_done,
    output logic switch_enable,
    output logic engine_active_flag,
    output logic test_mode_bit
);
    // bus request and its decode
    swc_req_t req;
    logic hit;
    logic wr_hit;
    logic rd_hit;

    // write data fields and command decode
    logic [2:0] wr_cmd;
    logic wr_test;
    logic stop_cmd;
    logic go_cmd;

    // stored fields and the read word
    logic [2:0] cmd_q;
    logic test_q;
    logic [15:0] rd_word;

    // run control state
    swc_state_t state_r;
    swc_state_t state_nxt;

    // engine cell handshake
    logic drain_done;
    logic stop_now;

    // read data register
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;

    // run control and test outputs with next values
    logic enable_r;
    logic enable_nxt;
    logic active_r;
    logic active_nxt;
    logic test_r;
    logic test_nxt;

    // bundle the bus request
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // address decode: one mapped word, every other address is refused
    always_comb begin
        hit = 1'b0;
        if (req.addr == SWC_CMD_OFFSET) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    // qualified strobes
    assign wr_hit = req.wr && hit;
    assign rd_hit = req.rd && hit;

    // write fields; version and reserved bits are never stored
    assign wr_cmd = req.wdata[SWC_CMD_MSB:SWC_CMD_LSB]; // R01 R03
    assign wr_test = req.wdata[SWC_TEST_BIT];

    // command decode of the written field
    assign stop_cmd = wr_hit && (wr_cmd == SWC_CMD_STOP);
    assign go_cmd = wr_hit && (wr_cmd == SWC_CMD_ENABLE);

    // command field storage, reads back as written
    swc_sync_reg #(
        .W(3),
        .RST(SWC_CMD_RESET)
    ) u_cmd (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .load(wr_hit),
        .d(wr_cmd), // R05
        .q(cmd_q)
    );

    // test mode bit storage
    swc_sync_reg #(
        .W(1),
        .RST(SWC_TEST_RESET)
    ) u_test (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .load(wr_hit),
        .d(wr_test), // R04
        .q(test_q)
    );

    // read word: fixed version, test bit, zero reserved bits, command
    assign rd_word = {SWC_VERSION, test_q, 4'h0, cmd_q}; // R02 R01

    // read data only for a mapped read, zero otherwise
    always_comb begin
        if (rd_hit) begin
            rdata_nxt = rd_word;
        end else begin
            rdata_nxt = SWC_RD_ZERO;
        end
    end

    // a cell ends on its done pulse, or is gone once cell_active drops
    assign drain_done = cell_done || !cell_active;

    // a stop with no cell in flight halts at once
    assign stop_now = stop_cmd && !cell_active;

    // run control: codes other than stop and enable keep the current state
    always_comb begin
        state_nxt = state_r; // R10
        case (state_r)
            SWC_ST_IDLE: begin
                if (go_cmd) begin
                    state_nxt = SWC_ST_RUN; // R05
                end
            end
            SWC_ST_RUN: begin
                if (stop_now) begin
                    state_nxt = SWC_ST_IDLE; // R05
                end else if (stop_cmd) begin
                    state_nxt = SWC_ST_DRAIN; // R07
                end
            end
            SWC_ST_DRAIN: begin
                if (go_cmd) begin
                    state_nxt = SWC_ST_RUN;
                end else if (drain_done) begin
                    state_nxt = SWC_ST_IDLE; // R07
                end
            end
            default: begin
                state_nxt = SWC_ST_IDLE;
            end
        endcase
    end

    // run control levels follow the next state, test mode level follows the written bit
    assign enable_nxt = (state_nxt == SWC_ST_RUN);
    assign active_nxt = (state_nxt != SWC_ST_IDLE);
    assign test_nxt = wr_hit ? wr_test : test_r; // R04

    // run control state register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= SWC_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // read data register, zero between reads
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= SWC_RD_ZERO;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // switch enable level
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            enable_r <= 1'b0;
        end else begin
            enable_r <= enable_nxt;
        end
    end

    // busy level, high while running or draining
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            active_r <= 1'b0;
        end else begin
            active_r <= active_nxt;
        end
    end

    // test mode output copy
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            test_r <= SWC_TEST_RESET;
        end else begin
            test_r <= test_nxt;
        end
    end

    // register read data straight from its flop
    assign reg_rdata = rdata_r;

    // run control levels straight from their flops
    assign switch_enable = enable_r;
    assign engine_active_flag = active_r;

    // test mode bit straight from its flop
    assign test_mode_bit = test_r;
endmodule // swc_cmd_reg

// file: dv/swc_cmd_reg_assertions.sv
// swc_cmd_reg_assertions: port checks of the command register
// assumes one clock, async active-low reset
`timescale 1ns/1ps
module swc_cmd_reg_chk import swc_pkg::*; (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic cell_active,
    input wire logic cell_done,
    input wire logic switch_enable,
    input wire logic engine_active_flag,
    input wire logic test_mode_bit
);
    // decoded accesses to the mapped word
    wire w0 = reg_wr && reg_addr == SWC_CMD_OFFSET;
    wire r0 = reg_rd && reg_addr == SWC_CMD_OFFSET;
    wire go = w0 && reg_wdata[2:0] == SWC_CMD_ENABLE;
    wire halt = w0 && reg_wdata[2:0] == SWC_CMD_STOP;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    a_ver_fixed: assert property (r0 |=> reg_rdata[15:8] == SWC_VERSION)
        else $error("bad version");
    a_rsvd_zero: assert property (r0 |=> reg_rdata[6:3] == 4'h0)
        else $error("reserved set");
    a_run_cmd: assert property (go |=> switch_enable && engine_active_flag)
        else $error("no run");
    a_stop_idle: assert property (halt && !cell_active |=> !engine_active_flag)
        else $error("no stop");
    a_stop_drain: assert property (halt && cell_active && switch_enable
        |=> !switch_enable && engine_active_flag)
        else $error("no drain");
    a_drain_hold: assert property (engine_active_flag && !switch_enable && cell_active
        && !cell_done && !go |=> engine_active_flag)
        else $error("cell cut");
    a_nop_hold: assert property (w0 && !go && !halt |=> $stable(switch_enable))
        else $error("nop acted");
    a_test_copy: assert property (w0 |=> test_mode_bit == $past(reg_wdata[7]))
        else $error("test bit lost");
endmodule // swc_cmd_reg_chk
bind swc_cmd_reg swc_cmd_reg_chk chk (.*);

// file: dv/swc_cmd_reg_tb.sv
// swc_cmd_reg_tb: directed register sequences for the command register
// assumes the register port and engine handshake of swc_cmd_reg
`timescale 1ns/1ps
module swc_cmd_reg_tb import swc_pkg::*;;
    logic core_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, cell_active = 0, cell_done = 0;
    logic [15:0] reg_addr = '0, reg_wdata = '0, reg_rdata;
    logic switch_enable, engine_active_flag, test_mode_bit;
    int fails = 0, n_compared = 0;
    always #50 core_clk = ~core_clk;
    swc_cmd_reg dut (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cell_active(cell_active), .cell_done(cell_done), .switch_enable(switch_enable),
        .engine_active_flag(engine_active_flag), .test_mode_bit(test_mode_bit));
    task cmp_d(input logic [15:0] g, e);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("ERROR %0t rdata %h exp %h", $time, g, e);
        end
    endtask
    // enable, busy, test mode as one vector
    task cmp_f(input logic [2:0] e);
        n_compared++;
        if ({switch_enable, engine_active_flag, test_mode_bit} !== e) begin
            fails++;
            $display("ERROR %0t flags exp %b", $time, e);
        end
    endtask
    task wr(input logic [15:0] a, d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task rd(input logic [15:0] a, e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 cmp_d(reg_rdata, e);
    endtask
    task close_out;
        if (fails == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(16'h0000, {SWC_VERSION, 8'h00});
        cmp_f(3'b000);
        wr(16'h0000, 16'hff87);
        cmp_f(3'b111);
        rd(16'h0000, {SWC_VERSION, 8'h87});
        wr(16'h0000, 16'h0003);
        cmp_f(3'b110);
        @(posedge core_clk);
        cell_active <= 1'b1;
        wr(16'h0000, 16'h0000);
        cmp_f(3'b010);
        repeat (3) @(posedge core_clk);
        cell_done <= 1'b1;
        cell_active <= 1'b0;
        #1 cmp_f(3'b010);
        @(posedge core_clk);
        cell_done <= 1'b0;
        #1 cmp_f(3'b000);
        wr(16'h0000, 16'h0005);
        cmp_f(3'b000);
        wr(16'h0004, 16'h0007);
        cmp_f(3'b000);
        rd(16'h0004, 16'h0000);
        wr(16'h0000, 16'h0007);
        cmp_f(3'b110);
        wr(16'h0000, 16'h0000);
        cmp_f(3'b000);
        close_out();
    end
    // hang guard, far beyond the sequence length
    initial begin
        #100000;
        fails++;
        close_out();
    end
endmodule // swc_cmd_reg_tb
